/* src/ilmr_pkg.sv */
// How it works
// - Bank literal load copies a 5-bit immediate into the bank select register
// - PC-high literal load copies a 7-bit immediate into the pc high latch
// - Accumulator literal load places the 8-bit immediate into the accumulator
// - Accumulator store writes the accumulator to file register at 7-bit address
// - Index mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// - Relative form addresses pointer plus signed offset -32..31, pointer unchanged
// - Afterwards pointer is plus one, minus one, or unchanged by mode
// - Indirect window accesses go to the address held by its file pointer
// - File pointer is 16 bits and wraps both ways
// - Indirect store and its pointer update touch no status flag
// - Software reset resets the device and clears the soft reset flag
// - Return from irq pops the stack and loads the top into the pc
// - Return from irq sets global irq enable, bit 7 of irq control
// - Return from irq takes two instruction cycles
package ilmr_pkg;

    localparam int          PC_W        = 15;
    localparam int          FSR_W       = 16;
    localparam int          STACK_DEPTH = 16;
    localparam int          AXI_AW      = 8;

    // Instruction classes in word bits 13:8
    localparam logic [5:0]  OPC_MISC    = 6'h00;
    localparam logic [5:0]  OPC_STORE   = 6'h02;
    localparam logic [5:0]  OPC_BANK    = 6'h03;
    localparam logic [5:0]  OPC_IND     = 6'h04;
    localparam logic [5:0]  OPC_IND_REL = 6'h05;
    localparam logic [5:0]  OPC_ACC_LIT = 6'h30;
    localparam logic [5:0]  OPC_PCH_LIT = 6'h31;
    localparam logic [7:0]  MISC_NOP    = 8'h00;
    localparam logic [7:0]  MISC_RESET  = 8'h01;
    localparam logic [7:0]  MISC_IRQ_RET = 8'h09;

    localparam logic [1:0]  MODE_PREINC  = 2'h0;
    localparam logic [1:0]  MODE_PREDEC  = 2'h1;
    localparam logic [1:0]  MODE_POSTINC = 2'h2;
    localparam logic [1:0]  MODE_POSTDEC = 2'h3;
    localparam logic [6:0]  WIN0_ADDR    = 7'h00;
    localparam logic [6:0]  WIN1_ADDR    = 7'h01;

    localparam int          IRQ_EN_BIT    = 7;
    localparam int          SRST_FLAG_BIT = 2;

    localparam logic [7:0]  OFS_ACC     = 8'h00;
    localparam logic [7:0]  OFS_BANK     = 8'h04;
    localparam logic [7:0]  OFS_PCH      = 8'h08;
    localparam logic [7:0]  OFS_FSR0     = 8'h0c;
    localparam logic [7:0]  OFS_FSR1     = 8'h10;
    localparam logic [7:0]  OFS_IRQ_CTRL = 8'h14;
    localparam logic [7:0]  OFS_PWR_CTRL = 8'h18;
    localparam logic [7:0]  OFS_PC      = 8'h1c;
    localparam logic [7:0]  OFS_STATUS  = 8'h20;

    localparam logic [7:0]  RST_ACC     = 8'h00;
    localparam logic [4:0]  RST_BANK      = 5'h00;
    localparam logic [6:0]  RST_PCH       = 7'h00;
    localparam logic [15:0] RST_FSR       = 16'h0000;
    localparam logic [7:0]  RST_IRQ_CTRL  = 8'h00;
    localparam logic        RST_SRST_FLAG = 1'b1;
    localparam logic [14:0] RST_PC      = 15'h0000;
    localparam logic [7:0]  RST_STATUS  = 8'h00;

    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_RET2 = 3'b010,
        ST_SRST = 3'b100
    } ilmr_state_t;

    typedef enum logic [3:0] {
        OP_NONE, OP_BANK, OP_PCH, OP_ACC, OP_STORE, OP_IND, OP_IND_REL, OP_RESET, OP_IRQ_RET
    } ilmr_op_t;

    typedef enum logic [3:0] {
        SEL_ACC, SEL_BANK, SEL_PCH, SEL_FSR0, SEL_FSR1, SEL_IRQ_CTRL, SEL_PWR_CTRL, SEL_PC, SEL_STATUS, SEL_NONE
    } ilmr_sel_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  data;
    } ilmr_mem_wr_t;

    function automatic ilmr_op_t ilmr_decode(input logic [13:0] w);
        ilmr_op_t op;
        op = OP_NONE;
        case (w[13:8])
            OPC_BANK:    op = OP_BANK;
            OPC_PCH_LIT: op = OP_PCH;
            OPC_ACC_LIT: op = OP_ACC;
            OPC_STORE:   op = OP_STORE;
            OPC_IND:     op = OP_IND;
            OPC_IND_REL: op = OP_IND_REL;
            OPC_MISC: begin
                if (w[7:0] == MISC_RESET) op = OP_RESET;
                else if (w[7:0] == MISC_IRQ_RET) op = OP_IRQ_RET;
            end
            default:     op = OP_NONE;
        endcase
        return op;
    endfunction : ilmr_decode

    function automatic ilmr_sel_t ilmr_reg_sel(input logic [7:0] a);
        ilmr_sel_t s;
        if (a == OFS_ACC) s = SEL_ACC;
        else if (a == OFS_BANK) s = SEL_BANK;
        else if (a == OFS_PCH) s = SEL_PCH;
        else if (a == OFS_FSR0) s = SEL_FSR0;
        else if (a == OFS_FSR1) s = SEL_FSR1;
        else if (a == OFS_IRQ_CTRL) s = SEL_IRQ_CTRL;
        else if (a == OFS_PWR_CTRL) s = SEL_PWR_CTRL;
        else if (a == OFS_PC) s = SEL_PC;
        else if (a == OFS_STATUS) s = SEL_STATUS;
        else s = SEL_NONE;
        return s;
    endfunction : ilmr_reg_sel

endpackage : ilmr_pkg

/* src/ilmr_stack.sv */
`timescale 1ns/1ps
module ilmr_stack import ilmr_pkg::*; (
    // Clock and synchronous clear
    input  wire logic            aclk,
    input  wire logic            clear,
    // Push and pop
    input  wire logic            push,
    input  wire logic [PC_W-1:0] push_data,
    input  wire logic            pop,
    output logic      [PC_W-1:0] top
);
    logic [PC_W-1:0] mem_reg [STACK_DEPTH];
    logic [3:0]      sp_reg;

    // Pointer wraps like a circular stack; overflow silently overwrites
    assign top = mem_reg[4'(sp_reg - 4'h1)];

    always_ff @(posedge aclk) begin
        if (clear) begin
            sp_reg <= 4'h0;
        end else if (pop) begin
            sp_reg <= 4'(sp_reg - 4'h1);
        end else if (push) begin
            sp_reg <= 4'(sp_reg + 4'h1);
        end
    end

    always_ff @(posedge aclk) begin
        if (push && !pop && !clear) begin
            mem_reg[sp_reg] <= push_data;
        end
    end
endmodule : ilmr_stack

/* src/ilmr_exec.sv */
`timescale 1ns/1ps
module ilmr_exec import ilmr_pkg::*; (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Instruction stream
    input  wire logic              instr_valid,
    input  wire logic [13:0]       instr_word,
    output logic                   instr_ready,
    // Call push from neighbouring logic
    input  wire logic              call_push,
    input  wire logic [PC_W-1:0]   call_ret_addr,
    // Core state out
    output ilmr_mem_wr_t           mem_wr,
    output logic [PC_W-1:0]        pc_out,
    output logic                   global_irq_enable,
    output logic                   soft_reset_pulse,
    // AXI4-Lite slave
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    // ==========================================================
    // Declarations
    ilmr_state_t       state_reg, state_next;
    ilmr_op_t          op;
    logic              ready_reg, fire, core_clear;
    logic [7:0]        acc_reg, irq_ctrl_reg, status_reg;
    logic [4:0]        bank_reg;
    logic [6:0]        pch_reg;
    logic [FSR_W-1:0]  fsr_reg [2];
    logic              srst_flag_reg, srst_reg;
    logic [PC_W-1:0]   pc_reg, ret_addr_reg, stack_top;
    ilmr_mem_wr_t      mem_wr_reg;
    logic              ind_n;
    logic [1:0]        ind_mode;
    logic [FSR_W-1:0]  fsr_sel, fsr_inc, fsr_dec, rel_off, ind_addr, fsr_after;
    logic [6:0]        file_f;
    logic [15:0]       direct_addr;
    logic              aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg;
    logic [7:0]        aw_addr_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic [1:0]        bresp_reg, rresp_reg;
    logic              arready_reg, rvalid_reg, bus_wr;
    logic [31:0]       rdata_reg, rd_word;
    ilmr_sel_t         wr_sel, rd_sel;
    logic [1:0]        fsr_bus_hit;

    assign instr_ready      = ready_reg;
    assign mem_wr           = mem_wr_reg;
    assign pc_out           = pc_reg;
    assign global_irq_enable = irq_ctrl_reg[IRQ_EN_BIT];
    assign soft_reset_pulse = srst_reg;
    assign s_axi_awready    = awready_reg;
    assign s_axi_wready     = wready_reg;
    assign s_axi_bvalid     = bvalid_reg;
    assign s_axi_bresp      = bresp_reg;
    assign s_axi_arready    = arready_reg;
    assign s_axi_rvalid     = rvalid_reg;
    assign s_axi_rdata      = rdata_reg;
    assign s_axi_rresp      = rresp_reg;

    assign fire       = instr_valid && ready_reg;
    assign op         = ilmr_decode(instr_word);
    // Software reset clears the core for one cycle, like a device reset
    assign core_clear = !aresetn || state_reg == ST_SRST;

    // ==========================================================
    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (fire && op == OP_IRQ_RET) state_next = ST_RET2;
                else if (fire && op == OP_RESET) state_next = ST_SRST;
            end
            ST_RET2: state_next = ST_RUN;
            ST_SRST: state_next = ST_RUN;
            default: state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_RUN;
            ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            // Single-cycle ops keep ready high, so they retire back to back
            ready_reg <= state_next == ST_RUN;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) srst_reg <= 1'b0;
        else srst_reg <= fire && op == OP_RESET;
    end

    // ==========================================================
    // Stack and program counter
    ilmr_stack u_stack (
        .aclk      (aclk),
        .clear     (core_clear),
        .push      (call_push),
        .push_data (call_ret_addr),
        .pop       (fire && op == OP_IRQ_RET),
        .top       (stack_top)
    );

    always_ff @(posedge aclk) begin
        if (core_clear) ret_addr_reg <= RST_PC;
        else if (fire && op == OP_IRQ_RET) ret_addr_reg <= stack_top;
    end

    always_ff @(posedge aclk) begin
        if (core_clear) pc_reg <= RST_PC;
        else if (state_reg == ST_RET2) pc_reg <= ret_addr_reg;
        else if (fire && op != OP_IRQ_RET && op != OP_RESET) pc_reg <= 15'(pc_reg + 15'h1);
    end

    // ==========================================================
    // Literal loads
    always_ff @(posedge aclk) begin
        if (core_clear) bank_reg <= RST_BANK;
        else if (fire && op == OP_BANK) bank_reg <= instr_word[4:0];
        else if (bus_wr && wr_sel == SEL_BANK && wstrb_reg[0]) bank_reg <= wdata_reg[4:0];
    end

    always_ff @(posedge aclk) begin
        if (core_clear) pch_reg <= RST_PCH;
        else if (fire && op == OP_PCH) pch_reg <= instr_word[6:0];
        else if (bus_wr && wr_sel == SEL_PCH && wstrb_reg[0]) pch_reg <= wdata_reg[6:0];
    end

    always_ff @(posedge aclk) begin
        if (core_clear) acc_reg <= RST_ACC;
        else if (fire && op == OP_ACC) acc_reg <= instr_word[7:0];
        else if (bus_wr && wr_sel == SEL_ACC && wstrb_reg[0]) acc_reg <= wdata_reg[7:0];
    end

    // Only software moves the status flags; no op here writes them
    always_ff @(posedge aclk) begin
        if (core_clear) status_reg <= RST_STATUS;
        else if (bus_wr && wr_sel == SEL_STATUS && wstrb_reg[0]) status_reg <= wdata_reg[7:0];
    end

    // ==========================================================
    // Address generation
    assign ind_n    = op == OP_IND ? instr_word[2] : instr_word[6];
    assign ind_mode = instr_word[1:0];
    assign fsr_sel  = fsr_reg[ind_n];
    assign fsr_inc  = 16'(fsr_sel + 16'h0001);
    assign fsr_dec  = 16'(fsr_sel - 16'h0001);
    assign rel_off  = {{10{instr_word[5]}}, instr_word[5:0]};
    assign file_f   = instr_word[6:0];

    always_comb begin
        ind_addr  = fsr_sel;
        fsr_after = fsr_sel;
        if (op == OP_IND_REL) begin
            ind_addr = 16'(fsr_sel + rel_off);
        end else begin
            case (ind_mode)
                MODE_PREINC:  begin ind_addr = fsr_inc; fsr_after = fsr_inc; end
                MODE_PREDEC:  begin ind_addr = fsr_dec; fsr_after = fsr_dec; end
                MODE_POSTINC: begin ind_addr = fsr_sel; fsr_after = fsr_inc; end
                default:      begin ind_addr = fsr_sel; fsr_after = fsr_dec; end
            endcase
        end
    end

    // The window has no storage: a direct store to it lands on the pointed address
    always_comb begin
        if (file_f == WIN0_ADDR) direct_addr = fsr_reg[0];
        else if (file_f == WIN1_ADDR) direct_addr = fsr_reg[1];
        else direct_addr = {4'h0, bank_reg, file_f};
    end

    assign fsr_bus_hit[0] = bus_wr && wr_sel == SEL_FSR0;
    assign fsr_bus_hit[1] = bus_wr && wr_sel == SEL_FSR1;

    for (genvar n = 0; n < 2; n++) begin : g_fsr
        always_ff @(posedge aclk) begin
            if (core_clear) begin
                fsr_reg[n] <= RST_FSR;
            end else if (fire && op == OP_IND && ind_n == 1'(n)) begin
                fsr_reg[n] <= fsr_after;
            end else if (fsr_bus_hit[n]) begin
                if (wstrb_reg[0]) fsr_reg[n][7:0] <= wdata_reg[7:0];
                if (wstrb_reg[1]) fsr_reg[n][15:8] <= wdata_reg[15:8];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (core_clear) begin
            mem_wr_reg <= '0;
        end else begin
            mem_wr_reg.valid <= fire && (op == OP_STORE || op == OP_IND || op == OP_IND_REL);
            mem_wr_reg.data  <= acc_reg;
            mem_wr_reg.addr  <= op == OP_STORE ? direct_addr : ind_addr;
        end
    end

    // ==========================================================
    // Interrupt control and power control
    always_ff @(posedge aclk) begin
        if (core_clear) begin
            irq_ctrl_reg <= RST_IRQ_CTRL;
        end else begin
            if (bus_wr && wr_sel == SEL_IRQ_CTRL && wstrb_reg[0]) irq_ctrl_reg <= wdata_reg[7:0];
            // Hardware set wins over a simultaneous software clear
            if (state_reg == ST_RET2) irq_ctrl_reg[IRQ_EN_BIT] <= 1'b1;
        end
    end

    // Survives software reset so the cause stays visible
    always_ff @(posedge aclk) begin
        if (!aresetn) srst_flag_reg <= RST_SRST_FLAG;
        else if (fire && op == OP_RESET) srst_flag_reg <= 1'b0;
        else if (bus_wr && wr_sel == SEL_PWR_CTRL && wstrb_reg[0]) srst_flag_reg <= wdata_reg[SRST_FLAG_BIT];
    end

    // ==========================================================
    // AXI4-Lite write channel
    assign wr_sel = ilmr_reg_sel(aw_addr_reg);
    assign bus_wr = aw_full_reg && w_full_reg && !bvalid_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            awready_reg <= 1'b1;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && awready_reg) begin
            aw_full_reg <= 1'b1;
            awready_reg <= 1'b0;
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
        end else if (bus_wr) begin
            aw_full_reg <= 1'b0;
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wready_reg <= 1'b1;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end else if (s_axi_wvalid && wready_reg) begin
            w_full_reg <= 1'b1;
            wready_reg <= 1'b0;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end else if (bus_wr) begin
            w_full_reg <= 1'b0;
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (bus_wr) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_sel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    assign rd_sel = ilmr_reg_sel({s_axi_araddr[7:2], 2'h0});

    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_sel)
            SEL_ACC:    rd_word[7:0]   = acc_reg;
            SEL_BANK:     rd_word[4:0]   = bank_reg;
            SEL_PCH:      rd_word[6:0]   = pch_reg;
            SEL_FSR0:     rd_word[15:0]  = fsr_reg[0];
            SEL_FSR1:     rd_word[15:0]  = fsr_reg[1];
            SEL_IRQ_CTRL: rd_word[7:0]   = irq_ctrl_reg;
            SEL_PWR_CTRL: rd_word[SRST_FLAG_BIT] = srst_flag_reg;
            SEL_PC:     rd_word[14:0]  = pc_reg;
            SEL_STATUS: rd_word[7:0]   = status_reg;
            default:    rd_word        = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_word;
            rresp_reg   <= rd_sel == SEL_NONE ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid_reg && s_axi_rready) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_bank;
        fire && op == OP_BANK |=> bank_reg == $past(instr_word[4:0]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank literal not loaded");

    property p_pch;
        fire && op == OP_PCH |=> pch_reg == $past(instr_word[6:0]);
    endproperty
    a_pch: assert property (p_pch) else $error("pc high literal not loaded");

    property p_acc;
        fire && op == OP_ACC |=> acc_reg == $past(instr_word[7:0]) && instr_ready;
    endproperty
    a_acc: assert property (p_acc) else $error("acc literal wrong or slow");

    property p_store;
        fire && op == OP_STORE && instr_word[6:1] != 6'h00 |=>
            mem_wr.valid && mem_wr.data == $past(acc_reg)
            && mem_wr.addr == {4'h0, $past(bank_reg), $past(instr_word[6:0])};
    endproperty
    a_store: assert property (p_store) else $error("acc store wrong");

    property p_window;
        fire && op == OP_STORE && instr_word[6:1] == 6'h00 |=> mem_wr.addr == $past(fsr_reg[instr_word[0]]);
    endproperty
    a_window: assert property (p_window) else $error("window not redirected");

    property p_preinc;
        fire && op == OP_IND && ind_mode == MODE_PREINC && !ind_n |=>
            mem_wr.addr == 16'($past(fsr_reg[0]) + 16'h0001) && fsr_reg[0] == mem_wr.addr;
    endproperty
    a_preinc: assert property (p_preinc) else $error("pre-increment wrong");

    property p_postdec;
        fire && op == OP_IND && ind_mode == MODE_POSTDEC && ind_n |=>
            mem_wr.addr == $past(fsr_reg[1]) && fsr_reg[1] == 16'($past(fsr_reg[1]) - 16'h0001);
    endproperty
    a_postdec: assert property (p_postdec) else $error("post-decrement wrong");

    property p_rel;
        fire && op == OP_IND_REL && ind_n && !fsr_bus_hit[1] |=>
            $stable(fsr_reg[1]) && mem_wr.addr == 16'(fsr_reg[1] + $past(rel_off));
    endproperty
    a_rel: assert property (p_rel) else $error("relative store wrong");

    property p_status;
        fire && !bus_wr |=> $stable(status_reg);
    endproperty
    a_status: assert property (p_status) else $error("status changed by op");

    sequence s_reset_op;
        fire && op == OP_RESET;
    endsequence
    property p_reset;
        s_reset_op |=> soft_reset_pulse && !srst_flag_reg && !instr_ready ##1 acc_reg == RST_ACC && pc_reg == RST_PC;
    endproperty
    a_reset: assert property (p_reset) else $error("software reset wrong");

    sequence s_ret_fire;
        fire && op == OP_IRQ_RET;
    endsequence
    sequence s_ret_busy;
        !instr_ready ##1 instr_ready;
    endsequence
    // The popped top is sampled two edges back, at the edge that took the return
    property p_return_from_irq;
        s_ret_fire |=> s_ret_busy and (##1 pc_reg == $past(stack_top, 2) && global_irq_enable);
    endproperty
    a_return_from_irq: assert property (p_return_from_irq) else $error("return from irq wrong");
endmodule : ilmr_exec

/* bench/test_literal_indirect_move_and_return_ops.sv */
`timescale 1ns/1ps
module test_literal_indirect_move_and_return_ops import ilmr_pkg::*; ;
    logic aclk = 1'b0, aresetn = 1'b0, instr_valid = 1'b0, call_push = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic instr_ready, global_irq_enable, soft_reset_pulse, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [13:0]       instr_word = 14'h0000;
    logic [PC_W-1:0]   call_ret_addr = 15'h0000, pc_out;
    logic [AXI_AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    ilmr_mem_wr_t      mem_wr;
    int                err_count = 0, compares = 0;
    always #10 aclk = ~aclk;
    ilmr_exec uut (.aclk, .aresetn, .instr_valid, .instr_word, .instr_ready, .call_push, .call_ret_addr,
        .mem_wr, .pc_out, .global_irq_enable, .soft_reset_pulse, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // ==========================================
    // Shared drivers
    task conclude;
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task tmo;
        chk("handshake", 32'h1, 32'h0);
        conclude();
    endtask : tmo
    // Valid stays up when another word follows, so no signal is assigned twice in one step
    task ins(input logic [13:0] w, input bit last = 1'b1);
        int i;
        instr_valid <= 1'b1;
        instr_word  <= w;
        // The word is taken at the edge where ready is sampled high
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (instr_ready === 1'b1) break;
        end
        if (i == 20) tmo();
        if (last) instr_valid <= 1'b0;
    endtask : ins
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        int i;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (i == 20) tmo();
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
        int i;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (i == 20) tmo();
        s_axi_rready <= 1'b0;
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    endtask : rd
    task wchk(input logic [15:0] a);
        @(negedge aclk);
        chk("mem_wr", {8'h01, a, 8'h3c}, {7'h00, mem_wr});
        @(posedge aclk);
    endtask : wchk
    // ==========================================
    // Scenarios
    task t_lit;
        rd(OFS_PWR_CTRL, 32'h4);
        ins(14'h0000, 1'b0);
        ins(14'h30a5, 1'b0);
        ins(14'h031f, 1'b0);
        ins(14'h317f);
        rd(OFS_ACC, 32'ha5);
        rd(OFS_BANK, 32'h1f);
        rd(OFS_PCH, 32'h7f);
        rd(OFS_PC, 32'h4);
        rd(OFS_STATUS, 32'h0);
    endtask : t_lit
    task t_ind;
        logic [15:0] a, n;
        ins(14'h303c, 1'b0);
        ins(14'h0245);
        wchk(16'h0fc5);
        wr(OFS_FSR0, 32'h1234);
        ins(14'h0200);
        wchk(16'h1234);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_FSR1, 32'h0100);
            ins({6'h04, 6'h01, m[1:0]});
            n = m[0] ? 16'h00ff : 16'h0101;
            a = m[1] ? 16'h0100 : n;
            wchk(a);
            rd(OFS_FSR1, {16'h0, n});
        end
        wr(OFS_FSR0, 32'hffff);
        ins(14'h0400);
        wchk(16'h0000);
        ins(14'h0401);
        wchk(16'hffff);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_FSR1, 32'h0200);
        ins(14'h0560);
        wchk(16'h01e0);
        ins(14'h055f);
        wchk(16'h021f);
        rd(OFS_FSR1, 32'h0200);
    endtask : t_ind
    task t_ret;
        @(posedge aclk);
        call_push     <= 1'b1;
        call_ret_addr <= 15'h1234;
        @(posedge aclk);
        call_push <= 1'b0;
        ins(14'h0009);
        @(negedge aclk);
        chk("ready", 32'h0, {31'h0, instr_ready});
        @(negedge aclk);
        chk("pc", 32'h1234, {17'h0, pc_out});
        chk("irq_enable", 32'h1, {31'h0, global_irq_enable});
        rd(OFS_IRQ_CTRL, 32'h80);
    endtask : t_ret
    task t_rst;
        ins(14'h0001);
        @(negedge aclk);
        chk("srst", 32'h1, {31'h0, soft_reset_pulse});
        rd(OFS_PC, 32'h0);
        rd(OFS_ACC, 32'h0);
        rd(OFS_PWR_CTRL, 32'h0);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h44, 32'h1, RESP_SLVERR);
    endtask : t_rst
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_lit();
        t_ind();
        t_ret();
        t_rst();
        conclude();
    end
endmodule : test_literal_indirect_move_and_return_ops
